// File: logic/miv_core.sv
/*
 * maskable interrupt response sequencer: request gating, acknowledge
 * transactions, opcode injection, program counter push, vector table
 * fetch and service routine address forming, plus its register port.
 * assumes one 50 mhz clock, a same-clock core that marks instruction
 * boundaries and answers each handshake, and an asynchronous request pin.
 */
// What this block does
// - mode 0: acknowledged byte executed as opcode
// - mode 0: repeat acknowledges for multi-byte opcodes
// - mode 0: no automatic program counter push
// - mode 0: undefined injected opcode takes trap
// - accepting interrupt clears both enable flags
// - mode 1: acknowledge run, data bus ignored
// - mode 1: push pc, restart at 38h
// - mode 2: push pc, load table entry
// - mode 2 address: base, page, 8-bit vector
// - mode 2 entry word or longword, even
// - mode 3: push pc, address base plus vector
// - mode 3 entry word or longword, even
// - primary flag 0 ignores all maskable requests
// - reset clears page and base registers
`timescale 1ns/1ps
`default_nettype none
`include "miv_regs.svh"

module miv_core (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [`MIV_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // request pin and core timing
  input wire logic maskable_request_in,
  input wire logic instr_boundary_i,
  input wire logic [31:0] cur_pc_i,
  // acknowledge transaction
  output logic ack_req_o,
  input wire logic ack_done_i,
  input wire logic [15:0] ack_data_i,
  // injected opcode towards the decoder
  output logic inject_valid_o,
  output logic [7:0] inject_opcode_o,
  input wire logic inject_ready_i,
  input wire logic inject_more_i,
  input wire logic inject_undef_i,
  output logic trap_o,
  // program counter push
  output logic push_req_o,
  output logic [31:0] push_pc_o,
  input wire logic push_done_i,
  // vector table read
  output logic tbl_rd_req_o,
  output logic [31:0] tbl_addr_o,
  output logic tbl_wide_o,
  input wire logic tbl_done_i,
  input wire logic [31:0] tbl_data_i,
  // new program counter
  output logic pc_load_o,
  output logic [31:0] pc_new_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////
  // request synchroniser

  logic req_meta_ff; // first stage, read only by second stage
  logic req_sync_ff; // second stage, safe to use
  logic nxt_req_meta;
  logic nxt_req_sync;

  // two stage capture of the pin level
  always_comb begin
    nxt_req_meta = maskable_request_in;
    nxt_req_sync = req_meta_ff;
  end

  // register the synchroniser stages
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_meta_ff <= 1'b0;
      req_sync_ff <= 1'b0;
    end else begin
      req_meta_ff <= nxt_req_meta;
      req_sync_ff <= nxt_req_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer state and datapath registers

  miv_pkg::miv_state_type state_ff; // current sequencer state
  miv_pkg::miv_state_type nxt_state;
  miv_pkg::miv_mode_type act_mode_ff; // mode latched at acceptance
  miv_pkg::miv_mode_type nxt_act_mode;
  logic [15:0] vec_ff; // captured vector
  logic [15:0] nxt_vec;
  logic [7:0] opc_ff; // injected opcode byte
  logic [7:0] nxt_opc;
  logic [31:0] push_pc_ff; // interrupted program counter
  logic [31:0] nxt_push_pc;
  logic [31:0] tbl_addr_ff; // table entry address
  logic [31:0] nxt_tbl_addr;
  logic [31:0] pc_new_ff; // service routine address
  logic [31:0] nxt_pc_new;
  logic pc_load_ff; // one cycle load pulse
  logic nxt_pc_load;
  logic trap_ff; // one cycle trap pulse
  logic nxt_trap;
  logic accept; // interrupt taken this cycle

  ////////////////////////////////////////////////////////////////////
  // software visible registers

  logic int_enable_flag_primary_ff; // primary enable
  logic nxt_int_enable_flag_primary;
  logic int_enable_flag_backup_ff; // backup enable
  logic nxt_int_enable_flag_backup;
  miv_pkg::miv_mode_type mode_ff; // selected response mode
  miv_pkg::miv_mode_type nxt_mode;
  logic wide_ff; // wide address mode
  logic nxt_wide;
  logic [7:0] page_ff; // vector page
  logic [7:0] nxt_page;
  logic [15:0] base_ff; // upper vector base
  logic [15:0] nxt_base;
  logic [31:0] rdata_ff; // read data, one cycle after strobe
  logic [31:0] nxt_rdata;

  // gate: boundary, synced request and primary flag
  assign accept = (state_ff == miv_pkg::MIV_ST_IDLE) && instr_boundary_i
                  && req_sync_ff && int_enable_flag_primary_ff;

  // register writes, acceptance clear and read mux
  always_comb begin
    nxt_int_enable_flag_primary = int_enable_flag_primary_ff;
    nxt_int_enable_flag_backup = int_enable_flag_backup_ff;
    nxt_mode = mode_ff;
    nxt_wide = wide_ff;
    nxt_page = page_ff;
    nxt_base = base_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `MIV_OFF_CTRL: begin
          nxt_int_enable_flag_primary = reg_wdata_i[`MIV_CTRL_EN_PRI];
          nxt_int_enable_flag_backup = reg_wdata_i[`MIV_CTRL_EN_BAK];
          nxt_mode = miv_pkg::miv_mode_type'(reg_wdata_i[`MIV_CTRL_MODE_HI:`MIV_CTRL_MODE_LO]);
          nxt_wide = reg_wdata_i[`MIV_CTRL_WIDE];
        end
        `MIV_OFF_PAGE: begin
          nxt_page = reg_wdata_i[7:0];
        end
        `MIV_OFF_BASE: begin
          nxt_base = reg_wdata_i[15:0];
        end
        default: begin
          // status and unmapped writes ignored
        end
      endcase
    end
    // acceptance clears both flags, over a same-cycle write
    if (accept) begin
      nxt_int_enable_flag_primary = 1'b0;
      nxt_int_enable_flag_backup = 1'b0;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `MIV_OFF_CTRL: begin
          nxt_rdata = {27'h0000000, wide_ff, mode_ff, int_enable_flag_backup_ff, int_enable_flag_primary_ff};
        end
        `MIV_OFF_PAGE: begin
          nxt_rdata = {24'h000000, page_ff};
        end
        `MIV_OFF_BASE: begin
          nxt_rdata = {16'h0000, base_ff};
        end
        `MIV_OFF_STAT: begin
          nxt_rdata = {vec_ff, 8'h00, req_sync_ff, 4'h0, state_ff};
        end
        default: begin
          nxt_rdata = 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end
  end

  // register file flops, reset clears page and base
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_enable_flag_primary_ff <= 1'b0;
      int_enable_flag_backup_ff <= 1'b0;
      mode_ff <= miv_pkg::miv_mode_type'(`MIV_RST_MODE);
      wide_ff <= 1'b0;
      page_ff <= `MIV_RST_PAGE;
      base_ff <= `MIV_RST_BASE;
      rdata_ff <= 32'h0000_0000;
    end else begin
      int_enable_flag_primary_ff <= nxt_int_enable_flag_primary;
      int_enable_flag_backup_ff <= nxt_int_enable_flag_backup;
      mode_ff <= nxt_mode;
      wide_ff <= nxt_wide;
      page_ff <= nxt_page;
      base_ff <= nxt_base;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // acknowledge sequencer

  // next state and datapath of the response sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_act_mode = act_mode_ff;
    nxt_vec = vec_ff;
    nxt_opc = opc_ff;
    nxt_push_pc = push_pc_ff;
    nxt_tbl_addr = tbl_addr_ff;
    nxt_pc_new = pc_new_ff;
    nxt_pc_load = 1'b0;
    nxt_trap = 1'b0;
    unique case (state_ff)
      miv_pkg::MIV_ST_IDLE: begin
        if (accept) begin
          nxt_act_mode = mode_ff;
          nxt_push_pc = cur_pc_i;
          nxt_state = miv_pkg::MIV_ST_ACK;
        end
      end
      miv_pkg::MIV_ST_ACK: begin
        // wait for the peripheral to end the acknowledge
        if (ack_done_i) begin
          unique case (act_mode_ff)
            miv_pkg::MIV_MODE_INJECT: begin
              nxt_opc = ack_data_i[7:0];
              nxt_state = miv_pkg::MIV_ST_INJECT;
            end
            miv_pkg::MIV_MODE_FIXED: begin
              nxt_state = miv_pkg::MIV_ST_PUSH;
            end
            miv_pkg::MIV_MODE_TABLE8: begin
              nxt_vec = {8'h00, ack_data_i[7:0]};
              nxt_tbl_addr = {base_ff, page_ff, ack_data_i[7:1], 1'b0};
              nxt_state = miv_pkg::MIV_ST_PUSH;
            end
            miv_pkg::MIV_MODE_TABLE16: begin
              nxt_vec = ack_data_i;
              nxt_tbl_addr = {base_ff, ack_data_i[15:1], 1'b0};
              nxt_state = miv_pkg::MIV_ST_PUSH;
            end
          endcase
        end
      end
      miv_pkg::MIV_ST_INJECT: begin
        // decoder takes the byte and reports its fate
        if (inject_ready_i) begin
          if (inject_undef_i) begin
            nxt_trap = 1'b1;
            nxt_state = miv_pkg::MIV_ST_IDLE;
          end else if (inject_more_i) begin
            nxt_state = miv_pkg::MIV_ST_ACK;
          end else begin
            nxt_state = miv_pkg::MIV_ST_IDLE;
          end
        end
      end
      miv_pkg::MIV_ST_PUSH: begin
        // push the interrupted program counter first
        if (push_done_i) begin
          if (act_mode_ff == miv_pkg::MIV_MODE_FIXED) begin
            nxt_pc_new = `MIV_FIXED_RESTART;
            nxt_pc_load = 1'b1;
            nxt_state = miv_pkg::MIV_ST_IDLE;
          end else begin
            nxt_state = miv_pkg::MIV_ST_FETCH;
          end
        end
      end
      miv_pkg::MIV_ST_FETCH: begin
        // word in narrow mode, longword in wide mode
        if (tbl_done_i) begin
          nxt_pc_new = wide_ff ? tbl_data_i : {16'h0000, tbl_data_i[15:0]};
          nxt_pc_load = 1'b1;
          nxt_state = miv_pkg::MIV_ST_IDLE;
        end
      end
      default: begin
        nxt_state = miv_pkg::MIV_ST_IDLE; // illegal codes recover
      end
    endcase
  end

  // sequencer flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= miv_pkg::MIV_ST_IDLE;
      act_mode_ff <= miv_pkg::MIV_MODE_INJECT;
      vec_ff <= 16'h0000;
      opc_ff <= 8'h00;
      push_pc_ff <= 32'h0000_0000;
      tbl_addr_ff <= 32'h0000_0000;
      pc_new_ff <= 32'h0000_0000;
      pc_load_ff <= 1'b0;
      trap_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      act_mode_ff <= nxt_act_mode;
      vec_ff <= nxt_vec;
      opc_ff <= nxt_opc;
      push_pc_ff <= nxt_push_pc;
      tbl_addr_ff <= nxt_tbl_addr;
      pc_new_ff <= nxt_pc_new;
      pc_load_ff <= nxt_pc_load;
      trap_ff <= nxt_trap;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  // handshakes from state, data from flops
  assign ack_req_o = (state_ff == miv_pkg::MIV_ST_ACK);
  assign inject_valid_o = (state_ff == miv_pkg::MIV_ST_INJECT);
  assign inject_opcode_o = opc_ff;
  assign push_req_o = (state_ff == miv_pkg::MIV_ST_PUSH);
  assign push_pc_o = push_pc_ff;
  assign tbl_rd_req_o = (state_ff == miv_pkg::MIV_ST_FETCH);
  assign tbl_addr_o = tbl_addr_ff;
  assign tbl_wide_o = wide_ff;
  assign pc_load_o = pc_load_ff;
  assign pc_new_o = pc_new_ff;
  assign trap_o = trap_ff;
  assign busy_o = (state_ff != miv_pkg::MIV_ST_IDLE);
  assign reg_rdata_o = rdata_ff;

endmodule

`default_nettype wire

// File: logic/miv_regs.svh
/*
 * register offsets, control field positions, reset values and fixed
 * addresses of the maskable interrupt vectoring block.
 * assumes inclusion by bare name from the core, the checker and the bench.
 */
`ifndef MIV_REGS_SVH
`define MIV_REGS_SVH

// register offsets on the plain register port
`define MIV_ADDR_W 4
`define MIV_OFF_CTRL 4'h0
`define MIV_OFF_PAGE 4'h4
`define MIV_OFF_BASE 4'h8
`define MIV_OFF_STAT 4'hc

// control register field positions
`define MIV_CTRL_EN_PRI 0
`define MIV_CTRL_EN_BAK 1
`define MIV_CTRL_MODE_LO 2
`define MIV_CTRL_MODE_HI 3
`define MIV_CTRL_WIDE 4

// reset values
`define MIV_RST_PAGE 8'h00
`define MIV_RST_BASE 16'h0000
`define MIV_RST_MODE 2'h0

// fixed restart address of mode 1
`define MIV_FIXED_RESTART 32'h0000_0038

`endif

// File: logic/miv_pkg.sv
/*
 * types of the maskable interrupt vectoring block.
 * assumes miv_regs.svh sits beside it.
 */
`default_nettype none

package miv_pkg;

  // response mode held by the processor
  typedef enum logic [1:0] {
    MIV_MODE_INJECT = 2'h0,
    MIV_MODE_FIXED = 2'h1,
    MIV_MODE_TABLE8 = 2'h2,
    MIV_MODE_TABLE16 = 2'h3
  } miv_mode_type;

  // acknowledge sequencer states
  typedef enum logic [2:0] {
    MIV_ST_IDLE,
    MIV_ST_ACK,
    MIV_ST_INJECT,
    MIV_ST_PUSH,
    MIV_ST_FETCH
  } miv_state_type;

endpackage

`default_nettype wire

// File: verif/miv_chk.sv
/* assertions on the ports of the vectoring core.
   assumes a bind onto miv_core and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "miv_regs.svh"
module miv_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [`MIV_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] cur_pc_i,
  input wire logic ack_req_o,
  input wire logic ack_done_i,
  input wire logic [15:0] ack_data_i,
  input wire logic inject_valid_o,
  input wire logic inject_ready_i,
  input wire logic inject_undef_i,
  input wire logic trap_o,
  input wire logic push_req_o,
  input wire logic [31:0] push_pc_o,
  input wire logic tbl_rd_req_o,
  input wire logic [31:0] tbl_addr_o,
  input wire logic tbl_wide_o,
  input wire logic pc_load_o,
  input wire logic [31:0] pc_new_o,
  input wire logic busy_o
);
  // shadows of control, page and base; values latched at acceptance
  logic [4:0] ctl_ff;
  logic [7:0] page_ff;
  logic [15:0] base_ff, vec_ff;
  logic [1:0] mode_ff;
  logic [31:0] pc_ff, pcq_ff;
  logic bq_ff;
  ////////////////////////////////
  // first busy cycle latches mode and pc and drops the flags
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_ff <= 5'h0;
      page_ff <= 8'h0;
      base_ff <= 16'h0;
      vec_ff <= 16'h0;
      mode_ff <= 2'h0;
      pc_ff <= 32'h0;
      pcq_ff <= 32'h0;
      bq_ff <= 1'b0;
    end else begin
      pcq_ff <= cur_pc_i;
      bq_ff <= busy_o;
      if (reg_wr_i && reg_addr_i == `MIV_OFF_CTRL) ctl_ff <= reg_wdata_i[4:0];
      if (reg_wr_i && reg_addr_i == `MIV_OFF_PAGE) page_ff <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == `MIV_OFF_BASE) base_ff <= reg_wdata_i[15:0];
      if (busy_o && !bq_ff) begin
        mode_ff <= ctl_ff[3:2];
        pc_ff <= pcq_ff;
        ctl_ff[1:0] <= 2'h0;
      end
      if (ack_req_o && ack_done_i) vec_ff <= ack_data_i;
    end
  end
  ////////////////////////////////
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  gate_primary_a: assert property (!busy_o && !ctl_ff[0] |=> !busy_o)
    else $error("request taken with primary flag clear");
  restart_fix_a: assert property (pc_load_o && mode_ff == 2'h1 |-> pc_new_o == `MIV_FIXED_RESTART)
    else $error("fixed restart address wrong");
  inject_nopush_a: assert property (bq_ff && mode_ff == 2'h0 |-> !push_req_o && !tbl_rd_req_o)
    else $error("push or fetch in opcode mode");
  tbl_form_a: assert property (tbl_rd_req_o |-> !tbl_addr_o[0] && tbl_wide_o == ctl_ff[4])
    else $error("table read size or alignment wrong");
  tbl_base_a: assert property (tbl_rd_req_o |-> tbl_addr_o[31:16] == base_ff)
    else $error("table read base wrong");
  page_vec_a: assert property (tbl_rd_req_o && mode_ff == 2'h2 |-> tbl_addr_o[15:1] == {page_ff, vec_ff[7:1]})
    else $error("byte vector address wrong");
  vec16_a: assert property (tbl_rd_req_o && mode_ff == 2'h3 |-> tbl_addr_o[15:1] == vec_ff[15:1])
    else $error("word vector address wrong");
  push_pc_a: assert property (push_req_o |-> push_pc_o == pc_ff)
    else $error("pushed pc wrong");
  undef_trap_a: assert property (inject_valid_o && inject_ready_i && inject_undef_i |=> trap_o)
    else $error("no trap on undefined opcode");
  cover property (pc_load_o && mode_ff == 2'h1);
  cover property (trap_o);
  cover property (tbl_rd_req_o && tbl_wide_o);
  cover property (pc_load_o && mode_ff == 2'h3 && !tbl_wide_o);
endmodule
bind miv_core miv_chk u_chk (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .cur_pc_i,
  .ack_req_o, .ack_done_i, .ack_data_i, .inject_valid_o, .inject_ready_i, .inject_undef_i, .trap_o,
  .push_req_o, .push_pc_o, .tbl_rd_req_o, .tbl_addr_o, .tbl_wide_o, .pc_load_o, .pc_new_o, .busy_o);
`default_nettype wire

// File: verif/miv_periph.sv
/* far-side peripheral model answering every handshake of the core.
   assumes the core clock; wait_i stretches each answer by cycles. */
`timescale 1ns/1ps
`default_nettype none
module miv_periph (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ack_req_i,
  input wire logic push_req_i,
  input wire logic tbl_rd_req_i,
  input wire logic inject_valid_i,
  input wire logic [15:0] vec_i,
  input wire logic [31:0] entry_i,
  input wire logic [1:0] nbytes_i,
  input wire logic undef_i,
  input wire logic [1:0] wait_i,
  output logic ack_done_o,
  output logic [15:0] ack_data_o,
  output logic push_done_o,
  output logic tbl_done_o,
  output logic [31:0] tbl_data_o,
  output logic inject_ready_o,
  output logic inject_more_o,
  output logic inject_undef_o
);
  logic [1:0] cnt_ff, byte_ff;
  logic [15:0] last_ff;
  logic hit, any;
  // answer after wait_i cycles of a pending request
  assign any = ack_req_i || push_req_i || tbl_rd_req_i || inject_valid_i;
  assign hit = cnt_ff == wait_i;
  assign ack_done_o = ack_req_i && hit;
  assign push_done_o = push_req_i && hit;
  assign tbl_done_o = tbl_rd_req_i && hit;
  assign inject_ready_o = inject_valid_i && hit;
  // released acknowledge bus shows a pattern that changes every cycle, table bus holds the inverted entry
  assign ack_data_o = ack_done_o ? vec_i + {14'h0, byte_ff} : ~last_ff;
  assign tbl_data_o = tbl_done_o ? entry_i : ~entry_i;
  assign inject_more_o = {1'b0, byte_ff} + 3'h1 < {1'b0, nbytes_i};
  assign inject_undef_o = undef_i && !inject_more_o;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 2'h0;
      byte_ff <= 2'h0;
      last_ff <= 16'h0;
    end else begin
      cnt_ff <= (hit || !any) ? 2'h0 : cnt_ff + 2'h1;
      if (inject_ready_o) byte_ff <= inject_more_o ? byte_ff + 2'h1 : 2'h0;
      last_ff <= ack_data_o;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
/* self-checking bench of the vectoring core in all four modes.
   assumes miv_periph on the far side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "miv_regs.svh"
module tb;
  logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, maskable_request_in, instr_boundary_i, undef;
  logic [`MIV_ADDR_W-1:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, cur_pc_i, push_pc_o, tbl_addr_o, tbl_data_i, pc_new_o, entry;
  logic ack_req_o, ack_done_i, inject_valid_o, inject_ready_i, inject_more_i, inject_undef_i, trap_o;
  logic push_req_o, push_done_i, tbl_rd_req_o, tbl_wide_o, tbl_done_i, pc_load_o, busy_o;
  logic [15:0] ack_data_i, vec;
  logic [7:0] inject_opcode_o, ops [4];
  logic [1:0] nbytes, wt;
  logic [31:0] got_push, got_tbl;
  int error_cnt, checks_done, n_inj, n_push, n_trap, n_load;
  miv_core u_dut (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .maskable_request_in, .instr_boundary_i, .cur_pc_i, .ack_req_o, .ack_done_i, .ack_data_i,
    .inject_valid_o, .inject_opcode_o, .inject_ready_i, .inject_more_i, .inject_undef_i, .trap_o,
    .push_req_o, .push_pc_o, .push_done_i, .tbl_rd_req_o, .tbl_addr_o, .tbl_wide_o, .tbl_done_i,
    .tbl_data_i, .pc_load_o, .pc_new_o, .busy_o);
  miv_periph u_per (.core_clk_i, .rst_n_i, .ack_req_i(ack_req_o), .push_req_i(push_req_o),
    .tbl_rd_req_i(tbl_rd_req_o), .inject_valid_i(inject_valid_o), .vec_i(vec), .entry_i(entry),
    .nbytes_i(nbytes), .undef_i(undef), .wait_i(wt), .ack_done_o(ack_done_i), .ack_data_o(ack_data_i),
    .push_done_o(push_done_i), .tbl_done_o(tbl_done_i), .tbl_data_o(tbl_data_i),
    .inject_ready_o(inject_ready_i), .inject_more_o(inject_more_i), .inject_undef_o(inject_undef_i));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk(reg_rdata_o, e);
  endtask
  // raise the request and log inject, push, table, load and trap events until idle again
  task go;
    logic seen;
    seen = 1'b0;
    n_inj = 0;
    n_push = 0;
    n_trap = 0;
    n_load = 0;
    @(posedge core_clk_i);
    maskable_request_in <= 1'b1;
    for (int i = 0; i < 60 && !(seen && !busy_o); i++) begin
      @(negedge core_clk_i);
      seen |= busy_o;
      if (inject_valid_o && inject_ready_i && n_inj < 4) begin
        ops[n_inj] = inject_opcode_o;
        n_inj++;
      end
      if (pc_load_o) n_load++;
      if (push_req_o && push_done_i) n_push++;
      if (push_req_o) got_push = push_pc_o;
      if (tbl_rd_req_o && tbl_done_i) got_tbl = tbl_addr_o;
      if (trap_o) n_trap++;
    end
    @(posedge core_clk_i);
    maskable_request_in <= 1'b0;
    @(negedge core_clk_i);
    chk({31'h0, busy_o}, 32'h0);
    chk({31'h0, seen}, 32'h1);
  endtask
  ////////////////////////////////
  task t_regs;
    rd(`MIV_OFF_PAGE, 32'h0);
    rd(`MIV_OFF_BASE, 32'h0);
    rd(4'h2, 32'h0);
    wr(`MIV_OFF_PAGE, 32'h5a);
    wr(`MIV_OFF_BASE, 32'habcd);
    rd(`MIV_OFF_BASE, 32'habcd);
    $display("regs done");
  endtask
  task t_mode1;
    vec = 16'h00ff;
    wr(`MIV_OFF_CTRL, 32'h4);
    maskable_request_in <= 1'b1;
    repeat (9) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk({31'h0, busy_o}, 32'h0);
    @(posedge core_clk_i);
    instr_boundary_i <= 1'b0;
    wr(`MIV_OFF_CTRL, 32'h7);
    repeat (9) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk({31'h0, busy_o}, 32'h0);
    @(posedge core_clk_i);
    instr_boundary_i <= 1'b1;
    go;
    chk(pc_new_o, 32'h38);
    chk(n_load, 32'h1);
    chk(got_push, cur_pc_i);
    rd(`MIV_OFF_CTRL, 32'h4);
    $display("mode1 done");
  endtask
  task t_mode2;
    wt = 2'h2;
    vec = 16'h0037;
    wr(`MIV_OFF_CTRL, 32'h1b);
    go;
    chk(got_tbl, 32'habcd_5a36);
    chk(pc_new_o, entry);
    chk(n_push, 32'h1);
    chk(n_load, 32'h1);
    $display("mode2 done");
  endtask
  task t_mode3;
    wt = 2'h0;
    vec = 16'h1235;
    wr(`MIV_OFF_CTRL, 32'h0f);
    go;
    chk(got_tbl, 32'habcd_1234);
    chk(pc_new_o, 32'h4320);
    chk(n_load, 32'h1);
    rd(`MIV_OFF_CTRL, 32'h0c);
    $display("mode3 done");
  endtask
  task t_mode0;
    nbytes = 2'h2;
    undef = 1'b1;
    vec = 16'h00c7;
    wr(`MIV_OFF_CTRL, 32'h03);
    go;
    chk(n_inj, 32'h2);
    chk({ops[0], ops[1]}, 32'hc7c8);
    chk(n_trap, 32'h1);
    chk(n_push, 32'h0);
    chk(n_load, 32'h0);
    $display("mode0 done");
  endtask
  // mid-run reset must clear page and base again
  task t_rst;
    wr(`MIV_OFF_PAGE, 32'ha5);
    wr(`MIV_OFF_BASE, 32'h5aa5);
    rd(`MIV_OFF_PAGE, 32'ha5);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(`MIV_OFF_PAGE, 32'h0);
    rd(`MIV_OFF_BASE, 32'h0);
    $display("reset done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    maskable_request_in = 1'b0;
    instr_boundary_i = 1'b1;
    cur_pc_i = 32'h1234_5678;
    vec = 16'h0;
    entry = 32'h8765_4320;
    nbytes = 2'h1;
    undef = 1'b0;
    wt = 2'h0;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_mode1;
    t_mode2;
    t_mode3;
    t_mode0;
    t_rst;
    summarize;
  end
  // cuts a hang well past the expected run of under two hundred cycles
  initial begin
    repeat (5000) @(posedge core_clk_i);
    error_cnt++;
    summarize;
  end
endmodule
`default_nettype wire
